// file: rtl/rsc_top.sv
// Module: radio state machine config register, auto-calibration and chip-ready timer
`timescale 1ns/1ps
// Operation
// [R01] Setting 0: no automatic calibration; only the calibrate strobe calibrates.
// [R02] Setting 1: calibrate on each IDLE to RX, TX or tx-synth-on move.
// [R03] Setting 2: calibrate on each automatic RX or TX return to IDLE.
// [R04] Setting 3: calibrate on every fourth automatic return to IDLE.
// [R05] Host should prefer setting 3 in wake-on-radio use to save current.
// [R06] Chip-ready low stays high until ripple counter expires the selected count.
// [R07] Delay settings 0..3 give expiry counts 1, 16, 64, 256.
// [R08] Oscillator on in power-down: host should pick delay setting 2.
// [R09] Oscillator off in power-down: setting 0 allowed, setting 2 advised.
// [R10] Bit 1 enables pin radio control; resets to zero.
// [R11] Bit 0 keeps oscillator running in SLEEP; resets to zero.
// [R12] Calibration select in bits 5:4 resets 0; delay field resets 1.
// [R13] Automatic IDLE return happens when next-state field selects IDLE at packet end.
// [R14] Reserved bits 7:6 ignore writes and read zero.
module rsc_top import rsc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  input wire logic calibrate_strobe,
  input wire logic idle_to_active,
  input wire logic rx_packet_end,
  input wire logic tx_packet_end,
  input wire logic [1:0] after_receive_next_state,
  input wire logic [1:0] after_transmit_next_state,
  input wire logic osc_stable,
  output logic cal_start,
  output logic chip_ready_low,
  output logic pin_ctrl_enable,
  output logic keep_osc_in_sleep
);
  // ==========================================================
  // Register
  logic [5:0] cfg_ff;
  logic [5:0] nxt_cfg;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [1:0] cal_sel;
  logic [1:0] pud_sel;
  logic cfg_hit;

  assign cal_sel = cfg_ff[RSC_CAL_LO+:2];
  assign pud_sel = cfg_ff[RSC_PUD_LO+:2];
  assign cfg_hit = cfg_addr == RSC_CFG0_ADDR;

  always_comb
  begin
    nxt_cfg = cfg_ff;
    nxt_rdata = rdata_ff;
    if (cfg_wr && cfg_hit)
    begin
      nxt_cfg = cfg_wdata[5:0]; // [R14]
    end
    if (cfg_rd)
    begin
      nxt_rdata = cfg_hit ? {2'h0, cfg_ff} : 8'h00; // [R14]
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      cfg_ff <= RSC_CFG0_RESET[5:0]; // [R12]
      rdata_ff <= 8'h00;
    end
    else
    begin
      cfg_ff <= nxt_cfg;
      rdata_ff <= nxt_rdata;
    end
  end

  // ==========================================================
  // Calibration trigger
  logic auto_idle;
  logic [1:0] ret_cnt_ff;
  logic [1:0] nxt_ret_cnt;
  logic cal_ff;
  logic nxt_cal;
  logic pin_ff;
  logic osc_ff;

  // A return counts only when the packet-end next state is IDLE
  assign auto_idle = (rx_packet_end && after_receive_next_state == RSC_NEXT_IDLE)
    || (tx_packet_end && after_transmit_next_state == RSC_NEXT_IDLE); // [R13]

  always_comb
  begin
    nxt_ret_cnt = ret_cnt_ff;
    nxt_cal = calibrate_strobe; // [R01]
    case (cal_sel)
      RSC_CAL_NEVER: nxt_cal = calibrate_strobe; // [R01]
      RSC_CAL_FROM_IDLE: nxt_cal = calibrate_strobe || idle_to_active; // [R02]
      RSC_CAL_TO_IDLE: nxt_cal = calibrate_strobe || auto_idle; // [R03]
      RSC_CAL_FOURTH:
      begin
        if (auto_idle)
        begin
          nxt_ret_cnt = ret_cnt_ff + 2'h1; // [R04]
          nxt_cal = calibrate_strobe || (ret_cnt_ff == RSC_FOURTH_LAST); // [R04]
        end
      end
      default: nxt_cal = calibrate_strobe;
    endcase
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      ret_cnt_ff <= 2'h0;
      cal_ff <= 1'b0;
      pin_ff <= 1'b0;
      osc_ff <= 1'b0;
    end
    else
    begin
      ret_cnt_ff <= nxt_ret_cnt;
      cal_ff <= nxt_cal;
      pin_ff <= nxt_cfg[RSC_PIN_BIT]; // [R10]
      osc_ff <= nxt_cfg[RSC_OSC_BIT]; // [R11]
    end
  end

  // ==========================================================
  // Chip-ready timer
  // Ripple counter runs on mclk, standing in for the crystal clock
  rsc_pup_e pup_ff;
  rsc_pup_e nxt_pup;
  logic [RSC_RIPPLE_BITS-1:0] rip_ff;
  logic [RSC_RIPPLE_BITS-1:0] nxt_rip;
  logic [8:0] exp_ff;
  logic [8:0] nxt_exp;
  logic [8:0] exp_target;
  logic rdy_ff;
  logic nxt_rdy;

  always_comb
  begin
    case (pud_sel)
      2'h0: exp_target = RSC_EXP_0; // [R07]
      2'h1: exp_target = RSC_EXP_1; // [R07]
      2'h2: exp_target = RSC_EXP_2; // [R07]
      default: exp_target = RSC_EXP_3; // [R07]
    endcase
  end

  always_comb
  begin
    nxt_pup = pup_ff;
    nxt_rip = rip_ff;
    nxt_exp = exp_ff;
    nxt_rdy = 1'b1;
    case (pup_ff)
      RSC_WAIT_OSC:
      begin
        nxt_rip = '0;
        nxt_exp = 9'h000;
        if (osc_stable)
        begin
          nxt_pup = RSC_COUNTING;
        end
      end
      RSC_COUNTING:
      begin
        nxt_rip = rip_ff + 1'b1;
        if (&rip_ff)
        begin
          nxt_exp = exp_ff + 9'h001;
          if (exp_ff + 9'h001 == exp_target)
          begin
            nxt_pup = RSC_READY; // [R06]
            nxt_rdy = 1'b0;
          end
        end
        if (!osc_stable)
        begin
          nxt_pup = RSC_WAIT_OSC;
          nxt_rdy = 1'b1;
        end
      end
      RSC_READY:
      begin
        nxt_rdy = 1'b0;
        if (!osc_stable)
        begin
          nxt_pup = RSC_WAIT_OSC;
          nxt_rdy = 1'b1;
        end
      end
      default: nxt_pup = RSC_WAIT_OSC;
    endcase
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      pup_ff <= RSC_WAIT_OSC;
      rip_ff <= '0;
      exp_ff <= 9'h000;
      rdy_ff <= 1'b1;
    end
    else
    begin
      pup_ff <= nxt_pup;
      rip_ff <= nxt_rip;
      exp_ff <= nxt_exp;
      rdy_ff <= nxt_rdy;
    end
  end

  assign cfg_rdata = rdata_ff;
  assign cal_start = cal_ff;
  assign chip_ready_low = rdy_ff;
  assign pin_ctrl_enable = pin_ff;
  assign keep_osc_in_sleep = osc_ff;

  // ==========================================================
  // Assertions
  // Cycles spent counting; saturates so the short-delay check fires once per start
  logic [6:0] pup_cyc_ff;
  logic [6:0] nxt_pup_cyc;

  always_comb
  begin
    nxt_pup_cyc = 7'h00;
    if (pup_ff == RSC_COUNTING)
    begin
      nxt_pup_cyc = (&pup_cyc_ff) ? pup_cyc_ff : pup_cyc_ff + 7'h01;
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      pup_cyc_ff <= 7'h00;
    end
    else
    begin
      pup_cyc_ff <= nxt_pup_cyc;
    end
  end

  sequence s_fourth_return;
    cal_sel == RSC_CAL_FOURTH && auto_idle && ret_cnt_ff == RSC_FOURTH_LAST;
  endsequence

  a_never_auto_cal: assert property (@(posedge mclk) disable iff (reset) // [R01]
    cal_sel == RSC_CAL_NEVER && !calibrate_strobe |=> !cal_start)
    else $error("calibration without strobe in setting 0");
  a_from_idle_cal: assert property (@(posedge mclk) disable iff (reset) // [R02]
    cal_sel == RSC_CAL_FROM_IDLE && idle_to_active |=> cal_start)
    else $error("no calibration leaving idle");
  a_to_idle_cal: assert property (@(posedge mclk) disable iff (reset) // [R03]
    cal_sel == RSC_CAL_TO_IDLE && auto_idle |=> cal_start)
    else $error("no calibration on return to idle");
  a_fourth_cal: assert property (@(posedge mclk) disable iff (reset) // [R04]
    s_fourth_return |=> cal_start)
    else $error("no calibration on fourth return");
  a_ready_held: assert property (@(posedge mclk) disable iff (reset) // [R06]
    $fell(chip_ready_low) && !$past(cfg_wr) |-> exp_ff == exp_target && rip_ff == '0)
    else $error("chip ready before timer expiry");
  a_short_delay: assert property (@(posedge mclk) disable iff (reset) // [R07]
    pup_ff == RSC_COUNTING && pud_sel == 2'h0 && osc_stable
    && pup_cyc_ff == 7'((1 << RSC_RIPPLE_BITS) - 1) |=> !chip_ready_low)
    else $error("setting 0 did not ready after one expiry");
  a_pin_bit: assert property (@(posedge mclk) disable iff (reset) // [R10]
    cfg_wr && cfg_hit |=> pin_ctrl_enable == $past(cfg_wdata[RSC_PIN_BIT]))
    else $error("pin control bit wrong");
  a_osc_bit: assert property (@(posedge mclk) disable iff (reset) // [R11]
    cfg_wr && cfg_hit |=> keep_osc_in_sleep == $past(cfg_wdata[RSC_OSC_BIT]))
    else $error("oscillator keep bit wrong");
  a_reserved_zero: assert property (@(posedge mclk) disable iff (reset) // [R14]
    cfg_rd |=> cfg_rdata[7:6] == 2'h0)
    else $error("reserved bits nonzero");
endmodule

// file: rtl/rsc_pkg.sv
// Package: register map and constants for the radio state machine config block
package rsc_pkg;
  localparam logic [7:0] RSC_CFG0_ADDR = 8'h18;
  localparam logic [7:0] RSC_CFG0_RESET = 8'h04;
  localparam int RSC_CAL_LO = 4;
  localparam int RSC_PUD_LO = 2;
  localparam int RSC_PIN_BIT = 1;
  localparam int RSC_OSC_BIT = 0;
  localparam logic [1:0] RSC_CAL_NEVER = 2'h0;
  localparam logic [1:0] RSC_CAL_FROM_IDLE = 2'h1;
  localparam logic [1:0] RSC_CAL_TO_IDLE = 2'h2;
  localparam logic [1:0] RSC_CAL_FOURTH = 2'h3;
  localparam logic [1:0] RSC_NEXT_IDLE = 2'h0;
  localparam int RSC_RIPPLE_BITS = 6;
  localparam logic [8:0] RSC_EXP_0 = 9'h001;
  localparam logic [8:0] RSC_EXP_1 = 9'h010;
  localparam logic [8:0] RSC_EXP_2 = 9'h040;
  localparam logic [8:0] RSC_EXP_3 = 9'h100;
  localparam logic [1:0] RSC_FOURTH_LAST = 2'h3;
  typedef enum logic [2:0]
  {
    RSC_WAIT_OSC = 3'b001,
    RSC_COUNTING = 3'b010,
    RSC_READY = 3'b100
  } rsc_pup_e;
endpackage

// file: test/rsc_host.sv
// Host model: drives the configuration strobes of the register port
`timescale 1ns/1ps
module rsc_host
(
  input wire logic mclk,
  input wire logic [7:0] cfg_rdata,
  output logic cfg_wr,
  output logic cfg_rd,
  output logic [7:0] cfg_addr,
  output logic [7:0] cfg_wdata
);
  // ====
  // Advised host settings
  localparam logic [1:0] CAL_WOR = 2'h3;
  localparam logic [1:0] PUD_ROBUST = 2'h2;
  initial
  begin
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_addr = 8'h00;
    cfg_wdata = 8'h00;
  end
  // ====
  // Transfers; idle lines invert so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    @(negedge mclk);
    cfg_wr = 1'b0;
    cfg_addr = ~a;
    cfg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    cfg_addr = a;
    cfg_rd = 1'b1;
    @(negedge mclk);
    cfg_rd = 1'b0;
    cfg_addr = ~a;
    d = cfg_rdata;
  endtask
  // Advised setup: every-fourth calibration with the robust power-up delay
  task automatic wr_wor();
    wr(rsc_pkg::RSC_CFG0_ADDR, {2'h0, CAL_WOR, PUD_ROBUST, 2'h0});
  endtask
endmodule

// file: test/rsc_top_tb_top.sv
// Testbench: register, calibration and chip-ready scenarios
`timescale 1ns/1ps
module rsc_top_tb_top;
  import rsc_pkg::*;
  logic mclk, reset, calibrate_strobe, idle_to_active, rx_packet_end, tx_packet_end;
  logic osc_stable, cfg_wr, cfg_rd, cal_start, chip_ready_low, pin_ctrl_enable;
  logic keep_osc_in_sleep;
  logic [1:0] after_receive_next_state, after_transmit_next_state;
  logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, rv;
  int err_total, cmp_count;
  int exp_n [4] = '{1, 16, 64, 256};
  rsc_top dut (.mclk, .reset, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata, .cfg_rdata,
    .calibrate_strobe, .idle_to_active, .rx_packet_end, .tx_packet_end,
    .after_receive_next_state, .after_transmit_next_state, .osc_stable,
    .cal_start, .chip_ready_low, .pin_ctrl_enable, .keep_osc_in_sleep);
  rsc_host host (.mclk, .cfg_rdata, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata);
  // ====
  // Common tasks
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("Checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic do_reset();
    reset = 1'b1;
    repeat (6) @(negedge mclk);
    reset = 1'b0;
  endtask
  // One event pulse; request answered one cycle later for one cycle only
  task automatic fire(input logic [3:0] p, input logic [1:0] ns, input logic e);
    {calibrate_strobe, idle_to_active, rx_packet_end, tx_packet_end} = p;
    after_receive_next_state = ns;
    after_transmit_next_state = ns;
    @(negedge mclk);
    {calibrate_strobe, idle_to_active, rx_packet_end, tx_packet_end} = 4'h0;
    check("cal_start", cal_start, e);
    @(negedge mclk);
    check("cal_start end", cal_start, 1'b0);
  endtask
  // ====
  // Scenarios
  task automatic t_reset_vals();
    check("pin reset", pin_ctrl_enable, 1'b0);
    check("osc reset", keep_osc_in_sleep, 1'b0);
    check("ready reset", chip_ready_low, 1'b1);
    host.rd(RSC_CFG0_ADDR, rv);
    check("cfg reset", rv, 8'h04);
  endtask
  task automatic t_regs();
    host.wr(RSC_CFG0_ADDR, 8'hff);
    check("pin set", pin_ctrl_enable, 1'b1);
    check("osc set", keep_osc_in_sleep, 1'b1);
    host.wr(8'h19, 8'h00);
    host.rd(RSC_CFG0_ADDR, rv);
    check("reserved drop", rv, 8'h3f);
    host.rd(8'h19, rv);
    check("unmapped read", rv, 8'h00);
    host.wr(RSC_CFG0_ADDR, 8'hc2);
    check("osc clear", keep_osc_in_sleep, 1'b0);
    check("pin kept", pin_ctrl_enable, 1'b1);
  endtask
  task automatic t_fourth();
    do_reset();
    host.wr_wor();
    fire(4'h8, 2'h0, 1'b1);
    for (int i = 1; i <= 8; i++)
    begin
      fire(4'h2, 2'h2, 1'b0);
      fire(4'h4, 2'h0, 1'b0);
      fire(i[0] ? 4'h2 : 4'h1, 2'h0, i % 4 == 0);
    end
  endtask
  task automatic t_modes();
    for (int s = 0; s < 3; s++)
    begin
      host.wr(RSC_CFG0_ADDR, {2'h0, 2'(s), 4'h4});
      fire(4'h8, 2'h0, 1'b1);
      fire(4'h4, 2'h0, s == 1);
      fire(4'h2, 2'h0, s == 2);
      fire(4'h1, 2'h0, s == 2);
      fire(4'h1, 2'h3, 1'b0);
    end
  endtask
  // Long settings kept: whole sweep stays near 22k cycles
  task automatic t_ready();
    int n;
    for (int s = 0; s < 4; s++)
    begin
      host.wr(RSC_CFG0_ADDR, {4'h0, 2'(s), 2'h0});
      osc_stable = 1'b1;
      n = 0;
      while (chip_ready_low !== 1'b0 && n < 20000)
      begin
        @(negedge mclk);
        n++;
      end
      check("ready delay", n > exp_n[s] * 64 && n <= exp_n[s] * 64 + 4, 1'b1);
      osc_stable = 1'b0;
      @(negedge mclk);
      check("ready drop", chip_ready_low, 1'b1);
    end
  endtask
  // ====
  // Clock, watchdog, main sequence
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial
  begin
    #300000;
    err_total++;
    close_out();
  end
  initial
  begin
    {calibrate_strobe, idle_to_active, rx_packet_end, tx_packet_end, osc_stable} = '0;
    after_receive_next_state = 2'h0;
    after_transmit_next_state = 2'h0;
    do_reset();
    t_reset_vals();
    t_regs();
    t_fourth();
    t_modes();
    t_ready();
    close_out();
  end
endmodule
